// [inc/dual_adc_sync_consts.svh]
// register map, field positions, reset values and delay counts
`ifndef DUAL_ADC_SYNC_CONSTS_SVH
`define DUAL_ADC_SYNC_CONSTS_SVH

`define STATUS_OFFSET      12'h000
`define CONTROL0_OFFSET    12'h004
`define CONTROL1_OFFSET    12'h008
`define RESULT_OFFSET      12'h04c

`define STAT_WDOG0_BIT     0
`define STAT_EOC_BIT       1
`define STAT_START_BIT     4
`define STAT_WDOG1_BIT     8

`define CTL0_SYNC_LSB      16
`define CTL0_SYNC_MSB      19
`define CTL0_EOC_IE_BIT    5
`define CTL0_WD0_IE_BIT    6
`define CTL0_WD1_IE_BIT    30

`define CTL1_CONT_BIT      1
`define CTL1_DMA_BIT       8
`define CTL1_TRIG_LSB      17
`define CTL1_TRIG_MSB      19

`define SYNC_FREE          4'h0
`define SYNC_PARALLEL      4'h6
`define SYNC_FOLLOW_FAST   4'h7
`define SYNC_FOLLOW_SLOW   4'h8

`define STATUS_RESET       32'h0000_0000
`define FAST_DELAY_CYCLES  4'h7
`define SLOW_DELAY_CYCLES  4'he

`endif

// [inc/dual_adc_sync_pkg.sv]
// types shared by the converter sync block
package dual_adc_sync_pkg;

	typedef enum {
		mode_free,
		mode_parallel,
		mode_fast,
		mode_slow
	} sync_mode_type;

	typedef enum {
		apb_idle,
		apb_answer
	} apb_state_type;

endpackage : dual_adc_sync_pkg

// [core/pin_edge_sync.sv]
// two-flop synchroniser with rising edge detect for a group of pins
`timescale 1ns/10ps
module pin_edge_sync #(
	parameter int width = 8
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic [width-1:0] pins_in,
	output logic      [width-1:0] rise_out
);

	typedef struct packed {
		logic [width-1:0] meta;
		logic [width-1:0] stable;
		logic [width-1:0] last;
		logic [width-1:0] rise;
	} edge_state_type;

	edge_state_type state;
	edge_state_type next_state;

	// meta is read only by stable, never by the edge logic
	always_comb begin
		next_state        = state;
		next_state.meta   = pins_in;
		next_state.stable = state.meta;
		next_state.last   = state.stable;
		next_state.rise   = state.stable & ~state.last;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign rise_out = state.rise;

endmodule : pin_edge_sync

// [core/slave_start_delay.sv]
// counts converter clock edges from a launch to the slave start
`timescale 1ns/10ps
module slave_start_delay (
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       launch_in,
	input  wire logic [3:0] cycles_in,
	input  wire logic       tick_in,
	output logic            done_out
);

	typedef struct packed {
		logic       busy;
		logic [3:0] count;
		logic       done;
	} delay_state_type;

	delay_state_type state;
	delay_state_type next_state;

	always_comb begin
		next_state      = state;
		next_state.done = 1'b0;
		if (launch_in) begin
			next_state.busy  = 1'b1;
			next_state.count = cycles_in;
		end else if (state.busy && tick_in) begin
			if (state.count == 4'h1) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
			end
			next_state.count = state.count - 4'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign done_out = state.done;

endmodule : slave_start_delay

// [core/dual_adc_sync_control.sv]
// coordination of two converter units: sync modes, flags, packed results
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "dual_adc_sync_consts.svh"
module dual_adc_sync_control
	import dual_adc_sync_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        arst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        converter_clock_in,
	input  wire logic [7:0]  ext_trigger_in,
	input  wire logic        master_own_trig_in,
	input  wire logic        slave_own_trig_in,
	input  wire logic        master_eoc_in,
	input  wire logic        slave_eoc_in,
	input  wire logic [15:0] master_data_in,
	input  wire logic [15:0] slave_data_in,
	input  wire logic        watchdog0_cross_in,
	input  wire logic        watchdog1_cross_in,
	input  wire logic        dma_ack_in,
	output logic             master_start_out,
	output logic             slave_start_out,
	output logic             dma_req_out,
	output logic [31:0]      dma_word_out,
	output logic             irq_out
);

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		apb_state_type apb;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
		logic          watchdog0_event_flag;
		logic          watchdog1_event_flag;
		logic          routine_start_flag;
		logic          eoc_flag;
		logic [3:0]    sync_mode_select;
		logic          end_of_conv_irq_en;
		logic          wd0_irq_en;
		logic          wd1_irq_en;
		logic          continuous_conversion;
		logic          dma_en;
		logic [2:0]    ext_trigger_source;
		logic [15:0]   master_data;
		logic [15:0]   slave_data;
		logic          master_done;
		logic          slave_done;
		logic [31:0]   routine_result_word;
		logic          dma_req;
		logic          irq;
		logic          master_start;
		logic          slave_start;
		logic          delay_launch;
		logic [3:0]    delay_cycles;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	logic [1:0] rst_pipe;
	logic       rst_n;
	logic [7:0] trig_rise;
	logic [0:0] conv_rise;
	logic       slave_delay_done;

	////////////////////////////////////////////////////////////////////////

	function automatic sync_mode_type decode_mode(input logic [3:0] sel);
		sync_mode_type m;
		case (sel)
			`SYNC_PARALLEL:    m = mode_parallel;
			`SYNC_FOLLOW_FAST: m = mode_fast;
			`SYNC_FOLLOW_SLOW: m = mode_slow;
			default:           m = mode_free;
		endcase
		return m;
	endfunction : decode_mode

	function automatic logic hit(input logic [11:0] addr,
	                             input logic [11:0] offset);
		return addr == offset;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////

	// release of the asynchronous reset passes two flops
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	pin_edge_sync #(
		.width(8)
	) trigger_sync (
		.mclk_in (mclk_in),
		.rst_n_in(rst_n),
		.pins_in (ext_trigger_in),
		.rise_out(trig_rise)
	);

	// the converter clock is slower than mclk, so edges are sampled
	pin_edge_sync #(
		.width(1)
	) conv_clock_sync (
		.mclk_in (mclk_in),
		.rst_n_in(rst_n),
		.pins_in (converter_clock_in),
		.rise_out(conv_rise)
	);

	slave_start_delay slave_delay (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n),
		.launch_in(state.delay_launch),
		.cycles_in(state.delay_cycles),
		.tick_in  (conv_rise[0]),
		.done_out (slave_delay_done)
	);

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic          access;
		logic          commit;
		logic          result_read;
		logic          launch;
		sync_mode_type mode;
		access      = 1'b0;
		commit      = 1'b0;
		result_read = 1'b0;
		launch      = 1'b0;
		mode        = decode_mode(state.sync_mode_select);
		next_state  = state;

		next_state.master_start = 1'b0;
		next_state.slave_start  = 1'b0;
		next_state.delay_launch = 1'b0;

		// apb: answer one cycle into the access phase
		access = psel_in && penable_in;
		commit = access && state.pready;
		case (state.apb)
			apb_idle: begin
				if (access) begin
					next_state.apb     = apb_answer;
					next_state.pready  = 1'b1;
					next_state.pslverr = 1'b0;
					next_state.prdata  = 32'h0000_0000;
					if (hit(paddr_in, `STATUS_OFFSET)) begin
						next_state.prdata[`STAT_WDOG0_BIT] =
							state.watchdog0_event_flag;
						next_state.prdata[`STAT_EOC_BIT]   = state.eoc_flag;
						next_state.prdata[`STAT_START_BIT] =
							state.routine_start_flag;
						next_state.prdata[`STAT_WDOG1_BIT] =
							state.watchdog1_event_flag;
					end else if (hit(paddr_in, `CONTROL0_OFFSET)) begin
						next_state.prdata[`CTL0_SYNC_MSB:`CTL0_SYNC_LSB] =
							state.sync_mode_select;
						next_state.prdata[`CTL0_EOC_IE_BIT] =
							state.end_of_conv_irq_en;
						next_state.prdata[`CTL0_WD0_IE_BIT] = state.wd0_irq_en;
						next_state.prdata[`CTL0_WD1_IE_BIT] = state.wd1_irq_en;
					end else if (hit(paddr_in, `CONTROL1_OFFSET)) begin
						next_state.prdata[`CTL1_CONT_BIT] =
							state.continuous_conversion;
						next_state.prdata[`CTL1_DMA_BIT] = state.dma_en;
						next_state.prdata[`CTL1_TRIG_MSB:`CTL1_TRIG_LSB] =
							state.ext_trigger_source;
					end else if (hit(paddr_in, `RESULT_OFFSET)) begin
						next_state.prdata = state.routine_result_word;
					end else begin
						next_state.pslverr = 1'b1;
					end
				end
			end
			apb_answer: begin
				if (commit) begin
					next_state.apb     = apb_idle;
					next_state.pready  = 1'b0;
					next_state.pslverr = 1'b0;
				end
			end
			default: begin
				next_state.apb    = apb_idle;
				next_state.pready = 1'b0;
			end
		endcase

		// register writes and read side effects land on the commit edge
		if (commit && pwrite_in) begin
			if (hit(paddr_in, `STATUS_OFFSET)) begin
				next_state.watchdog0_event_flag = state.watchdog0_event_flag
					& pwdata_in[`STAT_WDOG0_BIT];
				next_state.watchdog1_event_flag = state.watchdog1_event_flag
					& pwdata_in[`STAT_WDOG1_BIT];
				next_state.routine_start_flag = state.routine_start_flag
					& pwdata_in[`STAT_START_BIT];
				next_state.eoc_flag = state.eoc_flag
					& pwdata_in[`STAT_EOC_BIT];
			end else if (hit(paddr_in, `CONTROL0_OFFSET)) begin
				next_state.sync_mode_select =
					pwdata_in[`CTL0_SYNC_MSB:`CTL0_SYNC_LSB];
				next_state.end_of_conv_irq_en = pwdata_in[`CTL0_EOC_IE_BIT];
				next_state.wd0_irq_en = pwdata_in[`CTL0_WD0_IE_BIT];
				next_state.wd1_irq_en = pwdata_in[`CTL0_WD1_IE_BIT];
			end else if (hit(paddr_in, `CONTROL1_OFFSET)) begin
				next_state.continuous_conversion = pwdata_in[`CTL1_CONT_BIT];
				next_state.dma_en = pwdata_in[`CTL1_DMA_BIT];
				next_state.ext_trigger_source =
					pwdata_in[`CTL1_TRIG_MSB:`CTL1_TRIG_LSB];
			end
		end
		result_read = commit && !pwrite_in && hit(paddr_in, `RESULT_OFFSET);
		if (result_read) begin
			next_state.eoc_flag = 1'b0;
		end

		// trigger routing; software must keep triggers off busy converters
		case (mode)
			mode_free: begin
				next_state.master_start = master_own_trig_in;
				next_state.slave_start  = slave_own_trig_in;
			end
			mode_parallel: begin
				launch = trig_rise[state.ext_trigger_source];
				next_state.master_start = launch;
				next_state.slave_start  = launch;
			end
			mode_fast: begin
				launch = trig_rise[state.ext_trigger_source]
					|| (state.continuous_conversion && master_eoc_in);
				next_state.master_start = launch;
				next_state.delay_launch = launch;
				next_state.delay_cycles = `FAST_DELAY_CYCLES;
			end
			mode_slow: begin
				// continuous bit is ignored here: it would never stop
				launch = trig_rise[state.ext_trigger_source];
				next_state.master_start = launch;
				next_state.delay_launch = launch;
				next_state.delay_cycles = `SLOW_DELAY_CYCLES;
			end
			default: begin
				next_state.master_start = 1'b0;
			end
		endcase
		if (slave_delay_done && (mode == mode_fast || mode == mode_slow)) begin
			next_state.slave_start = 1'b1;
		end

		// in the sync modes converter results pair up into one word
		if (master_eoc_in) begin
			next_state.master_data = master_data_in;
			next_state.master_done = 1'b1;
		end
		if (slave_eoc_in) begin
			next_state.slave_data = slave_data_in;
			next_state.slave_done = 1'b1;
		end
		if (mode == mode_free) begin
			next_state.master_done = 1'b0;
			next_state.slave_done  = 1'b0;
			if (master_eoc_in) begin
				next_state.routine_result_word = {16'h0000, master_data_in};
			end
		end else if (state.master_done && state.slave_done) begin
			next_state.routine_result_word =
				{state.slave_data, state.master_data};
			next_state.master_done = master_eoc_in;
			next_state.slave_done  = slave_eoc_in;
			if (state.dma_en) begin
				next_state.dma_req = 1'b1;
			end
		end
		if (state.dma_req && dma_ack_in) begin
			next_state.dma_req = 1'b0;
		end

		// hardware sets win over a clear in the same cycle
		if (next_state.master_start) begin
			next_state.routine_start_flag = 1'b1;
		end
		if (master_eoc_in) begin
			next_state.eoc_flag = 1'b1;
		end
		if (watchdog0_cross_in) begin
			next_state.watchdog0_event_flag = 1'b1;
		end
		if (watchdog1_cross_in) begin
			next_state.watchdog1_event_flag = 1'b1;
		end

		// one shared line for both converters
		next_state.irq =
			(next_state.eoc_flag && state.end_of_conv_irq_en)
			|| (next_state.watchdog0_event_flag && state.wd0_irq_en)
			|| (next_state.watchdog1_event_flag && state.wd1_irq_en);
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			state     <= '0;
			state.apb <= apb_idle;
		end else begin
			state <= next_state;
		end
	end

	assign prdata_out       = state.prdata;
	assign pready_out       = state.pready;
	assign pslverr_out      = state.pslverr;
	assign master_start_out = state.master_start;
	assign slave_start_out  = state.slave_start;
	assign dma_req_out      = state.dma_req;
	assign dma_word_out     = state.routine_result_word;
	assign irq_out          = state.irq;

endmodule : dual_adc_sync_control

// [sim/dual_adc_sync_control_properties.sv]
// checker for the converter sync block, bound to its ports
`timescale 1ns/10ps
`include "dual_adc_sync_consts.svh"
module dual_adc_sync_control_properties (
	input wire logic        mclk_in,
	input wire logic        arst_n_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic        pready_out,
	input wire logic        converter_clock_in,
	input wire logic [7:0]  ext_trigger_in,
	input wire logic        slave_own_trig_in,
	input wire logic        master_eoc_in,
	input wire logic        slave_eoc_in,
	input wire logic [15:0] master_data_in,
	input wire logic [15:0] slave_data_in,
	input wire logic        master_start_out,
	input wire logic        slave_start_out,
	input wire logic        dma_req_out,
	input wire logic [31:0] dma_word_out,
	input wire logic        irq_out
);
	logic [31:0] ctl0, ctl1;
	logic        conv_q;
	logic [4:0]  edges;
	logic [15:0] ml, sl;
	wire         commit = psel_in && penable_in && pready_out && pwrite_in;
	wire [3:0]   mode = ctl0[`CTL0_SYNC_MSB:`CTL0_SYNC_LSB];
	wire [2:0]   tsel = ctl1[`CTL1_TRIG_MSB:`CTL1_TRIG_LSB];
	wire         sync_on = mode inside {4'h6, 4'h7, 4'h8};
	wire         no_en = !ctl0[5] && !ctl0[6] && !ctl0[30];
	////////////////////////////////////////////////////////////////////////
	// raw converter edges since the master start; sync lag allows one less
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctl0 <= 32'h0;
			ctl1 <= 32'h0;
			conv_q <= 1'b0;
			edges <= 5'h0;
			ml <= 16'h0;
			sl <= 16'h0;
		end else begin
			if (commit && paddr_in == `CONTROL0_OFFSET) ctl0 <= pwdata_in;
			if (commit && paddr_in == `CONTROL1_OFFSET) ctl1 <= pwdata_in;
			conv_q <= converter_clock_in;
			if (master_start_out) edges <= 5'h0;
			else if (converter_clock_in && !conv_q && edges < 5'h1f)
				edges <= edges + 5'h1;
			if (master_eoc_in) ml <= master_data_in;
			if (slave_eoc_in) sl <= slave_data_in;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	a_apb_one_wait: assert property (
		psel_in && penable_in && !pready_out |=> pready_out)
		else $error("apb answer late");
	a_par_together: assert property (
		mode == `SYNC_PARALLEL && master_start_out |-> slave_start_out)
		else $error("parallel slave start missing");
	a_fast_delay: assert property (
		mode == `SYNC_FOLLOW_FAST && slave_start_out |-> edges inside {[6:8]})
		else $error("fast slave delay wrong");
	a_slow_delay: assert property (
		mode == `SYNC_FOLLOW_SLOW && slave_start_out |-> edges inside {[13:15]})
		else $error("slow slave delay wrong");
	a_free_own: assert property (
		mode == `SYNC_FREE && slave_own_trig_in |-> ##[1:4] slave_start_out)
		else $error("free slave trigger lost");
	a_sync_trig: assert property (
		sync_on && $rose(ext_trigger_in[tsel]) |-> ##[2:6] master_start_out)
		else $error("shared trigger lost");
	a_dma_word: assert property (
		$rose(dma_req_out) |-> dma_word_out == {sl, ml})
		else $error("dma word packing wrong");
	a_irq_eoc: assert property (
		ctl0[`CTL0_EOC_IE_BIT] && master_eoc_in |-> ##[1:2] irq_out)
		else $error("eoc interrupt missing");
	a_irq_quiet: assert property (
		no_en && $past(no_en) |-> !irq_out)
		else $error("interrupt without enable");
endmodule : dual_adc_sync_control_properties

bind dual_adc_sync_control dual_adc_sync_control_properties
	dual_adc_sync_control_properties_i (.*);

// [sim/converter_pair_model.sv]
// behavioural pair of converter cores and a dma engine
`timescale 1ns/10ps
module converter_pair_model #(
	parameter int conv_cycles = 80
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        master_start_in,
	input  wire logic        slave_start_in,
	input  wire logic        dma_req_in,
	output logic             master_eoc_out,
	output logic             slave_eoc_out,
	output logic      [15:0] master_data_out,
	output logic      [15:0] slave_data_out,
	output logic             dma_ack_out
);
	int          mc, sc, ac;
	logic [15:0] mv, sv;
	logic        hold;
	// inverse outside the eoc cycle, so a stale value never passes
	assign master_data_out = master_eoc_out ? mv : ~mv;
	assign slave_data_out  = slave_eoc_out ? sv : ~sv;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mc <= 0;
			sc <= 0;
			ac <= 0;
			mv <= 16'h1000;
			sv <= 16'h2000;
			hold <= 1'b0;
			master_eoc_out <= 1'b0;
			slave_eoc_out <= 1'b0;
			dma_ack_out <= 1'b0;
		end else begin
			master_eoc_out <= (mc == 1);
			slave_eoc_out <= (sc == 1);
			if (master_eoc_out) mv <= mv + 16'h0111;
			if (slave_eoc_out) sv <= sv + 16'h0123;
			// a start while busy restarts the core; the bench never does it
			// each core samples its own channel, instantly at its start
			if (master_start_in) mc <= conv_cycles;
			else if (mc > 0) mc <= mc - 1;
			if (slave_start_in) sc <= conv_cycles;
			else if (sc > 0) sc <= sc - 1;
			// slow acceptor: four cycles of request, then one ack
			hold <= dma_ack_out || (hold && dma_req_in);
			ac <= (dma_req_in && !hold && !dma_ack_out) ? ac + 1 : 0;
			dma_ack_out <= dma_req_in && !hold && !dma_ack_out && ac == 3;
		end
	end
endmodule : converter_pair_model

// [sim/dual_adc_sync_control_test.sv]
// self-checking bench for the converter sync block
`timescale 1ns/10ps
`include "dual_adc_sync_consts.svh"
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", n, x, g); end end
`define WAIT(s, m) begin k = 0; while ((s) !== 1'b1 && k < m) begin \
	@(posedge mclk_in); k++; end if (k >= m) begin err_count++; \
	tally_and_finish; end end
module dual_adc_sync_control_test;
	logic        mclk_in, arst_n_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, dma_word_out, r, w;
	logic        pready_out, pslverr_out, converter_clock_in, e;
	logic [7:0]  ext_trigger_in;
	logic        master_own_trig_in, slave_own_trig_in, dma_ack_in;
	logic        master_eoc_in, slave_eoc_in, watchdog0_cross_in;
	logic        watchdog1_cross_in, master_start_out, slave_start_out;
	logic        dma_req_out, irq_out;
	logic [15:0] master_data_in, slave_data_in, em, es;
	int          err_count, compares, k, n;
	typedef struct packed {
		logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic err;
	} row_type;
	row_type     rows [9] = '{
		'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h008, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h04c, 32'h0, 32'h0, 1'b0},
		'{1'b1, 12'h004, 32'h4000_0060, 32'h0, 1'b0},
		'{1'b0, 12'h004, 32'h0, 32'h4000_0060, 1'b0},
		'{1'b1, 12'h008, 32'h000e_0102, 32'h0, 1'b0},
		'{1'b0, 12'h008, 32'h0, 32'h000e_0102, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h0, 1'b1}};
	logic [3:0]  md [3] = '{`SYNC_PARALLEL, `SYNC_FOLLOW_FAST, `SYNC_FOLLOW_SLOW};
	int          dl [3] = '{0, 7, 14};
	dual_adc_sync_control dual_adc_sync_control_i (.*);
	converter_pair_model converter_pair_model_i (.mclk_in(mclk_in),
		.rst_n_in(arst_n_in), .master_start_in(master_start_out),
		.slave_start_in(slave_start_out), .dma_req_in(dma_req_out),
		.master_eoc_out(master_eoc_in), .slave_eoc_out(slave_eoc_in),
		.master_data_out(master_data_in), .slave_data_out(slave_data_in),
		.dma_ack_out(dma_ack_in));
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	initial begin
		converter_clock_in = 1'b0;
		forever #16 converter_clock_in = ~converter_clock_in;
	end
	always @(posedge mclk_in) begin
		if (master_eoc_in === 1'b1) em <= master_data_in;
		if (slave_eoc_in === 1'b1) es <= slave_data_in;
	end
	task tally_and_finish;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		`WAIT(pready_out, 20)
		r = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge mclk_in);
	endtask : apb
	task rd(input string nm, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(nm, x, r)
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
		{ext_trigger_in, master_own_trig_in, slave_own_trig_in} = '0;
		{watchdog0_cross_in, watchdog1_cross_in} = '0;
		{arst_n_in, err_count, compares} = '0;
		repeat (10) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK("rdata", rows[i].x, r)
			`CHK("pslverr", rows[i].err, e)
		end
		$display("register table done");
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, `CONTROL0_OFFSET, 32'h0);
			apb(1'b1, `CONTROL1_OFFSET, 32'h100 | (32'(m + 1) << 17));
			apb(1'b1, `CONTROL0_OFFSET, {12'h0, md[m], 16'h0020});
			apb(1'b1, `STATUS_OFFSET, 32'h0);
			ext_trigger_in <= 8'h01 << (m + 1);
			@(posedge mclk_in);
			ext_trigger_in <= 8'h0;
			`WAIT(master_start_out, 20)
			if (m == 0) `CHK("paired start", 1'b1, slave_start_out)
			else begin
				@(posedge mclk_in);
				`WAIT(slave_start_out, 200)
				`CHK("delay", 1'b1, (k >= dl[m] * 8 - 10 && k <= dl[m] * 8 + 8))
			end
			`WAIT(dma_req_out, 300)
			w = {es, em};
			`CHK("dma word", w, dma_word_out)
			`WAIT(!dma_req_out, 20)
			`CHK("irq", 1'b1, irq_out)
			rd("status", `STATUS_OFFSET, 32'h12);
			rd("result", `RESULT_OFFSET, w);
			rd("status", `STATUS_OFFSET, 32'h10);
			apb(1'b1, `STATUS_OFFSET, 32'h0);
			rd("status", `STATUS_OFFSET, 32'h0);
			$display("sync mode %0d done", m);
		end
		for (int c = 0; c < 6; c += 5) begin
			apb(1'b1, `CONTROL0_OFFSET, 32'(c) << 16);
			master_own_trig_in <= 1'b1;
			@(posedge mclk_in);
			master_own_trig_in <= 1'b0;
			`WAIT(master_start_out, 8)
			`CHK("lone master", 1'b0, slave_start_out)
			slave_own_trig_in <= 1'b1;
			@(posedge mclk_in);
			slave_own_trig_in <= 1'b0;
			`WAIT(slave_start_out, 8)
			`CHK("lone slave", 1'b0, master_start_out)
			repeat (200) @(posedge mclk_in);
			`CHK("free dma", 1'b0, dma_req_out)
		end
		$display("free mode done");
		apb(1'b1, `CONTROL0_OFFSET, 32'h0000_0040);
		apb(1'b1, `STATUS_OFFSET, 32'h0);
		watchdog1_cross_in <= 1'b1;
		@(posedge mclk_in);
		watchdog1_cross_in <= 1'b0;
		rd("status", `STATUS_OFFSET, 32'h100);
		`CHK("masked irq", 1'b0, irq_out)
		watchdog0_cross_in <= 1'b1;
		@(posedge mclk_in);
		watchdog0_cross_in <= 1'b0;
		rd("status", `STATUS_OFFSET, 32'h101);
		`CHK("wd irq", 1'b1, irq_out)
		apb(1'b1, `STATUS_OFFSET, 32'h100);
		rd("status", `STATUS_OFFSET, 32'h100);
		`CHK("cleared irq", 1'b0, irq_out)
		$display("watchdog done");
		apb(1'b1, `CONTROL0_OFFSET, 32'h0);
		apb(1'b1, `CONTROL1_OFFSET, 32'h0002_0102);
		apb(1'b1, `CONTROL0_OFFSET, 32'h0007_0000);
		ext_trigger_in <= 8'h02;
		@(posedge mclk_in);
		ext_trigger_in <= 8'h0;
		n = 0;
		repeat (400) begin
			@(posedge mclk_in);
			if (master_start_out === 1'b1) n++;
		end
		`CHK("relaunch", 1'b1, (n >= 3))
		arst_n_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		`CHK("reset out", 3'b000, {master_start_out, dma_req_out, irq_out})
		arst_n_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rd("control1", `CONTROL1_OFFSET, 32'h0);
		rd("status", `STATUS_OFFSET, `STATUS_RESET);
		$display("continuous and reset done");
		tally_and_finish;
	end
endmodule : dual_adc_sync_control_test
